// File: uart_sideband_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the sideband block
// Assumes: Byte offsets on an 8-bit register address
// Notes: Definitions only
`ifndef UART_SIDEBAND_DEFINES_SVH
`define UART_SIDEBAND_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_FIFO_CTL 8'h04
`define OFS_XCVR_CTL 8'h08
`define OFS_GATE_CTL 8'h0c
`define OFS_STATUS 8'h10
`define OFS_DIV 8'h14
`define CTRL_POL 0
`define CTRL_EXT 1
`define CTRL_CKM_LO 2
`define CTRL_CKM_HI 3
`define CTRL_COMPAT 4
`define FCTL_FIFO_EN 0
`define FCTL_DMA_MODE 3
`define FCTL_TXT_LO 4
`define FCTL_TXT_HI 5
`define FCTL_RXT_LO 6
`define FCTL_RXT_HI 7
`define XCTL_MULTIDROP 0
`define XCTL_RCV_POL 1
`define XCTL_XMIT_POL 2
`define GCTL_RCV_AUTO 0
`define GCTL_XMIT_AUTO 1
`define GCTL_RCV_SW 2
`define GCTL_XMIT_SW 3
`define CTRL_RST 8'h02
`define FIFO_CTL_RST 8'h00
`define XCVR_CTL_RST 8'h06
`define GATE_CTL_RST 8'h03
`define DIV_RST 8'h0f
`define FIFO_DEPTH 5'h10
`endif

// File: uart_sideband_pkg.sv
// Purpose: Types shared by the sideband block
// Assumes: Constants come from uart_sideband_defines.svh
// Notes: Clock mode two selects the serial-rate update
package uart_sideband_pkg;
   typedef enum logic [1:0] {
      CKM_BUS = 2'b00,
      CKM_BUS_ALT = 2'b01,
      CKM_SERIAL = 2'b10,
      CKM_RSV = 2'b11
   } clk_mode_t;
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } tick_state_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] fifo_ctl;
      logic [7:0] xcvr_ctl;
      logic [7:0] gate_ctl;
      logic [7:0] div;
      logic [7:0] rdata;
      logic tx_req;
      logic rx_req;
      logic tx_blk;
      logic rx_blk;
      logic tx_single;
      logic rx_single;
      logic txrdy;
      logic rxrdy;
      logic rcv_on;
      logic xmit_on;
      logic rcv_pin;
      logic xmit_pin;
      logic mode_flag;
      logic idle_bus;
      logic idle_ser;
      logic sout_q;
   } side_state_t;
endpackage

// File: serial_tick_gen.sv
// Purpose: Serial-rate enable pulse from the bus clock
// Assumes: Divide value from software, zero means every cycle
// Notes: One-cycle pulse every div+1 cycles
`timescale 1ns/1ps
module serial_tick_gen
   import uart_sideband_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] div,
   output logic tick
);
   tick_state_t st_reg;
   tick_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt >= div) begin
         st_next.cnt = 8'h00;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;

   tick_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tick |-> st_reg.cnt == 8'h00)
      else $error("tick without counter wrap");
endmodule

// File: uart_sideband.sv
// Purpose: DMA handshake, line transceiver gates, idle hints and debug bus of a UART
// Assumes: FIFO counts and events come from core logic on mclk
// Notes: The serial domain is a serial-rate enable on the one clock
`timescale 1ns/1ps
`include "uart_sideband_defines.svh"

// How it works
// [RULE1] Transmit request asserts when transmit buffer needs service, polarity selectable.
// [RULE2] Receive request asserts when receive buffer needs service, same polarity.
// [RULE3] Transmit single flag shows at least one free transmit entry, no request.
// [RULE4] Receive single flag shows a free receive entry, requests nothing.
// [RULE5] DMA transmit acknowledge arrives on the bus clock, polarity selectable.
// [RULE6] DMA receive acknowledge arrives on the bus clock, polarity selectable.
// [RULE7] Without extended handshake, singles and acks vanish; legacy low-true ready outputs.
// [RULE8] Idle hints, bus and serial rate, high while the UART is inactive.
// [RULE9] Debug bus: 31:14 zero, 13 rx push, 12 tx pop, triggers below.
// [RULE10] Debug bit 7 DMA mode, bit 0 FIFO enable.
// [RULE11] Debug bits 6:1 show the six interrupt sources in order.
// [RULE12] Legacy-compatible setting keeps the busy-detect debug bit low.
// [RULE13] Receiver gate automatic when its auto bit is 1, else software value.
// [RULE14] Driver gate automatic when its auto bit is 1, else software value.
// [RULE15] Driver gate is on before transmission starts; the code holds shifting back in RS485 mode only, never in RS232.
// [RULE16] Receiver gate is on before reception starts.
// [RULE17] Receiver gate polarity from transceiver control bit 1, driver from its own bit.
// [RULE18] Registered mode flag: 0 RS232, 1 RS485.
// [RULE19] Gates and serial output update at serial rate in clock mode 2.
module uart_sideband
   import uart_sideband_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic [4:0] tx_count,
   input wire logic [4:0] rx_count,
   input wire logic tx_pop,
   input wire logic rx_push,
   input wire logic [5:0] irq_src,
   input wire logic tx_shift_busy,
   input wire logic rx_shift_busy,
   input wire logic sout_core,
   input wire logic dma_tx_ack_in,
   input wire logic dma_rx_ack_in,
   output logic dma_tx_req,
   output logic dma_rx_req,
   output logic dma_tx_single,
   output logic dma_rx_single,
   output logic txrdy_n,
   output logic rxrdy_n,
   output logic rcv_line_gate,
   output logic xmit_line_gate,
   output logic xmit_permit,
   output logic multidrop_mode_flag,
   output logic idle_gate_hint_bus_clk,
   output logic idle_gate_hint_serial_clk,
   output logic sout,
   output logic [31:0] debug
);
   side_state_t st_reg;
   side_state_t st_next;
   logic ser_tick;
   logic ser_en;
   logic pol;
   logic ext;
   logic tx_need;
   logic rx_need;
   logic tx_ack;
   logic rx_ack;
   logic xmit_auto;
   logic rcv_auto;
   logic [7:0] rd_mux;

   // Transmit need level for the empty trigger field
   function automatic logic [4:0] tx_level(input logic [1:0] trig);
      case (trig)
         2'b00: tx_level = 5'h00;
         2'b01: tx_level = 5'h02;
         2'b10: tx_level = 5'h04;
         default: tx_level = 5'h08;
      endcase
   endfunction

   // Receive need level for the receive trigger field
   function automatic logic [4:0] rx_level(input logic [1:0] trig);
      case (trig)
         2'b00: rx_level = 5'h01;
         2'b01: rx_level = 5'h04;
         2'b10: rx_level = 5'h08;
         default: rx_level = `FIFO_DEPTH - 5'h02;
      endcase
   endfunction

   serial_tick_gen u_tick (
      .mclk(mclk),
      .rst_n(rst_n),
      .div(st_reg.div),
      .tick(ser_tick)
   );

   assign pol = st_reg.ctrl[`CTRL_POL];
   assign ext = st_reg.ctrl[`CTRL_EXT];
   // [RULE19] serial-rate update
   assign ser_en = (st_reg.ctrl[`CTRL_CKM_HI:`CTRL_CKM_LO] == CKM_SERIAL) ? ser_tick : 1'b1;

   always_comb begin
      // FIFO off or single mode serves one character at a time
      if (st_reg.fifo_ctl[`FCTL_FIFO_EN] && st_reg.fifo_ctl[`FCTL_DMA_MODE]) begin
         tx_need = tx_count <= tx_level(st_reg.fifo_ctl[`FCTL_TXT_HI:`FCTL_TXT_LO]);
         rx_need = rx_count >= rx_level(st_reg.fifo_ctl[`FCTL_RXT_HI:`FCTL_RXT_LO]);
      end else begin
         tx_need = tx_count == 5'h00;
         rx_need = rx_count != 5'h00;
      end
   end

   // [RULE5] transmit ack decode
   assign tx_ack = ext & (dma_tx_ack_in ^ pol);
   // [RULE6] receive ack decode
   assign rx_ack = ext & (dma_rx_ack_in ^ pol);

   // Auto mode: driver on while data waits or shifts, receiver on otherwise
   assign xmit_auto = tx_count != 5'h00 || tx_shift_busy;
   assign rcv_auto = !xmit_auto;

   always_comb begin
      case (addr)
         `OFS_CTRL: rd_mux = st_reg.ctrl;
         `OFS_FIFO_CTL: rd_mux = st_reg.fifo_ctl;
         `OFS_XCVR_CTL: rd_mux = st_reg.xcvr_ctl;
         `OFS_GATE_CTL: rd_mux = st_reg.gate_ctl;
         `OFS_STATUS: rd_mux = {1'b0, st_reg.idle_ser, st_reg.idle_bus, st_reg.mode_flag,
            st_reg.xmit_on, st_reg.rcv_on, st_reg.rx_req, st_reg.tx_req};
         `OFS_DIV: rd_mux = st_reg.div;
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.rdata = rd_stb ? rd_mux : 8'h00;
      if (wr_stb) begin
         case (addr)
            `OFS_CTRL: st_next.ctrl = wdata;
            `OFS_FIFO_CTL: st_next.fifo_ctl = wdata;
            `OFS_XCVR_CTL: st_next.xcvr_ctl = wdata;
            `OFS_GATE_CTL: st_next.gate_ctl = wdata;
            `OFS_DIV: st_next.div = wdata;
            default: st_next.div = st_reg.div;
         endcase
      end
      // Ack holds the request off until the need falls; an ack in that cycle wins
      st_next.tx_blk = tx_ack | (st_reg.tx_blk & tx_need);
      st_next.rx_blk = rx_ack | (st_reg.rx_blk & rx_need);
      // [RULE1] transmit request
      st_next.tx_req = tx_need & !st_next.tx_blk;
      // [RULE2] receive request
      st_next.rx_req = rx_need & !st_next.rx_blk;
      // [RULE3] transmit free entry
      st_next.tx_single = ext & (tx_count < `FIFO_DEPTH);
      // [RULE4] receive free entry
      st_next.rx_single = ext & (rx_count < `FIFO_DEPTH);
      // [RULE7] legacy ready outputs
      st_next.txrdy = !ext & tx_need;
      st_next.rxrdy = !ext & rx_need;
      // [RULE18] mode flag
      st_next.mode_flag = st_reg.xcvr_ctl[`XCTL_MULTIDROP];
      // [RULE8] bus-rate idle
      st_next.idle_bus = tx_count == 5'h00 && rx_count == 5'h00 && !tx_shift_busy &&
         !rx_shift_busy && !st_reg.tx_req && !st_reg.rx_req;
      if (ser_en) begin
         // [RULE8] serial-rate idle
         st_next.idle_ser = !tx_shift_busy && !rx_shift_busy && tx_count == 5'h00;
         st_next.sout_q = sout_core;
         // [RULE14] driver gate source
         st_next.xmit_on = st_reg.gate_ctl[`GCTL_XMIT_AUTO] ? xmit_auto :
            st_reg.gate_ctl[`GCTL_XMIT_SW];
         // [RULE13] receiver gate source
         st_next.rcv_on = st_reg.gate_ctl[`GCTL_RCV_AUTO] ? rcv_auto :
            st_reg.gate_ctl[`GCTL_RCV_SW];
         // [RULE17] pin polarity
         st_next.xmit_pin = st_next.xmit_on ~^ st_reg.xcvr_ctl[`XCTL_XMIT_POL];
         st_next.rcv_pin = st_next.rcv_on ~^ st_reg.xcvr_ctl[`XCTL_RCV_POL];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.ctrl <= `CTRL_RST;
         st_reg.fifo_ctl <= `FIFO_CTL_RST;
         st_reg.xcvr_ctl <= `XCVR_CTL_RST;
         st_reg.gate_ctl <= `GATE_CTL_RST;
         st_reg.div <= `DIV_RST;
         st_reg.rcv_pin <= 1'b1;
         // Receiver state starts on so that it agrees with its pin
         st_reg.rcv_on <= 1'b1;
         st_reg.sout_q <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   // [RULE1] polarity on the pin
   assign dma_tx_req = st_reg.tx_req ^ pol;
   // [RULE2] polarity on the pin
   assign dma_rx_req = st_reg.rx_req ^ pol;
   // [RULE7] singles idle without extended handshake
   assign dma_tx_single = ext ? (st_reg.tx_single ^ pol) : pol;
   assign dma_rx_single = ext ? (st_reg.rx_single ^ pol) : pol;
   assign txrdy_n = !st_reg.txrdy;
   assign rxrdy_n = !st_reg.rxrdy;
   assign rcv_line_gate = st_reg.rcv_pin;
   assign xmit_line_gate = st_reg.xmit_pin;
   // [RULE15] core shifts only once the driver is on in RS485 mode, always in RS232; [RULE16] receiver on while idle
   assign xmit_permit = st_reg.xmit_on | !st_reg.mode_flag;
   assign multidrop_mode_flag = st_reg.mode_flag;
   assign idle_gate_hint_bus_clk = st_reg.idle_bus;
   assign idle_gate_hint_serial_clk = st_reg.idle_ser;
   assign sout = st_reg.sout_q;

   // Unregistered on purpose: it mirrors live state for probing
   always_comb begin
      debug = 32'h0000_0000;
      // [RULE9] push, pop and triggers
      debug[13] = rx_push;
      debug[12] = tx_pop;
      debug[11:10] = st_reg.fifo_ctl[`FCTL_RXT_HI:`FCTL_RXT_LO];
      debug[9:8] = st_reg.fifo_ctl[`FCTL_TXT_HI:`FCTL_TXT_LO];
      // [RULE10] DMA mode and FIFO enable
      debug[7] = st_reg.fifo_ctl[`FCTL_DMA_MODE];
      debug[0] = st_reg.fifo_ctl[`FCTL_FIFO_EN];
      // [RULE11] interrupt sources
      debug[6:2] = irq_src[5:1];
      // [RULE12] busy detect masked
      debug[1] = irq_src[0] & !st_reg.ctrl[`CTRL_COMPAT];
   end

   tx_req_follow_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
      (tx_need && !tx_ack && !st_reg.tx_blk) |=> (dma_tx_req != $past(pol)) || $changed(pol))
      else $error("transmit request missing");
   rx_req_follow_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
      (rx_need && !rx_ack && !st_reg.rx_blk) |=> (dma_rx_req != $past(pol)) || $changed(pol))
      else $error("receive request missing");
   tx_single_room_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
      (ext && tx_count < `FIFO_DEPTH) ##1 $stable(st_reg.ctrl) |-> dma_tx_single != pol)
      else $error("transmit single missing");
   rx_single_room_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
      (ext && rx_count < `FIFO_DEPTH) ##1 $stable(st_reg.ctrl) |-> dma_rx_single != pol)
      else $error("receive single missing");
   legacy_ready_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
      ext ##1 ext |-> txrdy_n && rxrdy_n)
      else $error("legacy outputs active with extended handshake");
   ack_drops_req_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
      tx_ack |=> !st_reg.tx_req ##1 (st_reg.tx_req -> !st_reg.tx_blk))
      else $error("request held through acknowledge");
   rx_ack_drops_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
      rx_ack |=> !st_reg.rx_req)
      else $error("receive request held through acknowledge");
   debug_upper_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
      debug[31:14] == 18'h00000 && debug[13] == rx_push && debug[12] == tx_pop)
      else $error("debug upper bits wrong");
   busy_masked_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
      st_reg.ctrl[`CTRL_COMPAT] |-> !debug[1])
      else $error("busy detect shown in legacy mode");
   gate_polarity_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
      ($past(ser_en) && $stable(st_reg.xcvr_ctl)) |->
         rcv_line_gate == (st_reg.rcv_on ~^ st_reg.xcvr_ctl[1]))
      else $error("receiver gate polarity wrong");
   mode_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE18]
      $rose(st_reg.xcvr_ctl[`XCTL_MULTIDROP]) |=> multidrop_mode_flag)
      else $error("mode flag late");
   serial_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE19]
      (st_reg.ctrl[3:2] == CKM_SERIAL && !ser_tick) |=> $stable(xmit_line_gate) && $stable(sout))
      else $error("serial outputs moved off the serial tick");
   auto_driver_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
      (st_reg.gate_ctl[1] && ser_en && tx_count != 5'h00) |=> st_reg.xmit_on)
      else $error("driver gate not on with data queued");
   idle_hint_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
      (tx_shift_busy || rx_shift_busy) |=> !idle_gate_hint_bus_clk)
      else $error("idle hint while active");
   singles_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
      !ext |-> dma_tx_single == pol && dma_rx_single == pol)
      else $error("single flags active without extended handshake");
   legacy_tx_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
      (!ext && tx_need) |=> !txrdy_n)
      else $error("legacy transmit ready missing");
   legacy_rx_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
      (!ext && rx_need) |=> !rxrdy_n)
      else $error("legacy receive ready missing");
   ack_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
      (!ext && tx_need && !st_reg.tx_blk) |=> st_reg.tx_req)
      else $error("acknowledge honoured without extended handshake");
   tx_single_full_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
      (ext && tx_count == `FIFO_DEPTH) ##1 $stable(st_reg.ctrl) |-> dma_tx_single == pol)
      else $error("transmit single with no room");
   debug_low_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
      debug[7] == st_reg.fifo_ctl[`FCTL_DMA_MODE] && debug[0] == st_reg.fifo_ctl[`FCTL_FIFO_EN])
      else $error("debug mode bits wrong");
   irq_order_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
      debug[6:2] == irq_src[5:1])
      else $error("debug interrupt sources out of order");
   busy_shown_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
      !st_reg.ctrl[`CTRL_COMPAT] |-> debug[1] == irq_src[0])
      else $error("busy detect not shown");
   auto_receiver_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
      (st_reg.gate_ctl[`GCTL_RCV_AUTO] && ser_en && tx_count != 5'h00) |=> !st_reg.rcv_on)
      else $error("receiver gate on with data queued");
   rcv_ready_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
      (st_reg.gate_ctl[`GCTL_RCV_AUTO] && ser_en && tx_count == 5'h00 && !tx_shift_busy)
         |=> st_reg.rcv_on)
      else $error("receiver gate off while idle");
   permit_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
      (multidrop_mode_flag && !st_reg.xmit_on) |-> !xmit_permit)
      else $error("shift permitted before driver gate");
   xmit_polarity_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
      ($past(ser_en) && $stable(st_reg.xcvr_ctl)) |->
         xmit_line_gate == (st_reg.xmit_on ~^ st_reg.xcvr_ctl[2]))
      else $error("driver gate polarity wrong");
   mode_fall_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE18]
      $fell(st_reg.xcvr_ctl[`XCTL_MULTIDROP]) |=> !multidrop_mode_flag)
      else $error("mode flag stuck in RS485");
   idle_serial_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
      (ser_en && (tx_shift_busy || rx_shift_busy)) |=> !idle_gate_hint_serial_clk)
      else $error("serial idle hint while active");
   rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data outside its cycle");

   tx_service_c: cover property (@(posedge mclk) disable iff (!rst_n)
      st_reg.tx_req ##1 tx_ack ##1 !st_reg.tx_req);
   rx_service_c: cover property (@(posedge mclk) disable iff (!rst_n)
      st_reg.rx_req ##1 rx_ack);
   turnaround_c: cover property (@(posedge mclk) disable iff (!rst_n)
      st_reg.xmit_on ##[1:50] st_reg.rcv_on);
   legacy_c: cover property (@(posedge mclk) disable iff (!rst_n)
      !ext && !txrdy_n);
   serial_gate_c: cover property (@(posedge mclk) disable iff (!rst_n)
      st_reg.ctrl[3:2] == CKM_SERIAL && ser_tick && st_reg.xmit_on);
endmodule

// File: dma_partner.sv
// Purpose: DMA controller stand-in that answers block requests with an acknowledge
// Assumes: Requests and acks live on mclk; pol mirrors the handshake polarity
// Notes: The active pulse is registered, the idle level follows pol at once so a
//  polarity change never reads as a spurious ack
`timescale 1ns/1ps
module dma_partner (
   input wire logic mclk,
   input wire logic pol,
   input wire logic [3:0] lat,
   input wire logic tx_req,
   input wire logic rx_req,
   input wire logic tx_go,
   input wire logic rx_go,
   output logic tx_ack,
   output logic rx_ack
);
   logic [3:0] tcnt = 4'h0;
   logic [3:0] rcnt = 4'h0;
   logic thit = 1'b0;
   logic rhit = 1'b0;
   always @(posedge mclk) begin
      tcnt <= (tx_go && (tx_req ^ pol)) ? tcnt + 4'h1 : 4'h0;
      rcnt <= (rx_go && (rx_req ^ pol)) ? rcnt + 4'h1 : 4'h0;
      thit <= tx_go && (tx_req ^ pol) && (tcnt == lat);
      rhit <= rx_go && (rx_req ^ pol) && (rcnt == lat);
   end
   assign tx_ack = pol ^ thit;
   assign rx_ack = pol ^ rhit;
endmodule

// File: uart_sideband_tb.sv
// Purpose: Self-checking bench of the UART sideband block
// Assumes: One clock, register bus with read data one cycle later
// Notes: Scenario tasks each drive and judge their own case
`timescale 1ns/1ps
`include "uart_sideband_defines.svh"
module uart_sideband_tb;
   import uart_sideband_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
   logic [4:0] tx_count = 5'h10, rx_count = 5'h00;
   logic tx_pop = 1'b0, rx_push = 1'b0, tx_shift_busy = 1'b0, rx_shift_busy = 1'b0;
   logic [5:0] irq_src = 6'h00;
   logic sout_core = 1'b1, dma_tx_ack_in, dma_rx_ack_in, pol = 1'b0, tx_go = 1'b0;
   logic rx_go = 1'b0, dma_tx_req, dma_rx_req, dma_tx_single, dma_rx_single;
   logic txrdy_n, rxrdy_n, rcv_line_gate, xmit_line_gate, xmit_permit;
   logic multidrop_mode_flag, idle_gate_hint_bus_clk, idle_gate_hint_serial_clk, sout;
   logic [31:0] debug;
   int failures = 0, comparisons = 0;

   always #50 mclk = ~mclk;

   uart_sideband dut (.mclk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .tx_count,
      .rx_count, .tx_pop, .rx_push, .irq_src, .tx_shift_busy, .rx_shift_busy, .sout_core,
      .dma_tx_ack_in, .dma_rx_ack_in, .dma_tx_req, .dma_rx_req, .dma_tx_single,
      .dma_rx_single, .txrdy_n, .rxrdy_n, .rcv_line_gate, .xmit_line_gate, .xmit_permit,
      .multidrop_mode_flag, .idle_gate_hint_bus_clk, .idle_gate_hint_serial_clk, .sout,
      .debug);
   dma_partner far (.mclk, .pol, .lat(4'h2), .tx_req(dma_tx_req), .rx_req(dma_rx_req),
      .tx_go, .rx_go, .tx_ack(dma_tx_ack_in), .rx_ack(dma_rx_ack_in));

   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      // Partner idle level must flip on the edge the control write lands
      if (a == `OFS_CTRL) pol <= d[0];
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_lvl(input int sel, input logic lvl);
      int i;
      logic s;
      for (i = 0; i < 20; i++) begin
         s = (sel == 0) ? dma_tx_req : (sel == 1) ? dma_rx_req : sout;
         if (s === lvl) return;
         cyc(1);
      end
      failures++;
      end_of_test();
   endtask
   task automatic set_counts(input logic [4:0] t, input logic [4:0] r);
      @(posedge mclk);
      tx_count <= t;
      rx_count <= r;
      cyc(2);
   endtask

   task automatic t_regs();
      logic [7:0] exp [4] = '{8'h02, 8'h06, 8'h03, 8'h0f};
      logic [7:0] ofs [4] = '{`OFS_CTRL, `OFS_XCVR_CTL, `OFS_GATE_CTL, `OFS_DIV};
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i], rv);
         check("reset value", rv, exp[i]);
      end
      rd(8'h20, rv);
      check("unmapped read", rv, 8'h00);
   endtask
   task automatic t_polarity();
      set_counts(5'h00, 5'h01);
      check("tx req pol0", dma_tx_req, 1'b1);
      check("rx req pol0", dma_rx_req, 1'b1);
      check("tx single pol0", dma_tx_single, 1'b1);
      wr(`OFS_CTRL, 8'h03);
      cyc(2);
      check("tx req pol1", dma_tx_req, 1'b0);
      check("rx req pol1", dma_rx_req, 1'b0);
      set_counts(5'h10, 5'h10);
      check("tx idle pol1", dma_tx_req, 1'b1);
      check("tx full single", dma_tx_single, 1'b1);
      check("rx full single", dma_rx_single, 1'b1);
      wr(`OFS_CTRL, 8'h02);
      cyc(2);
      check("tx full pol0", dma_tx_single, 1'b0);
      check("rx full pol0", dma_rx_single, 1'b0);
   endtask
   task automatic t_levels();
      logic [4:0] tl [4] = '{5'd0, 5'd2, 5'd4, 5'd8};
      logic [4:0] rl [4] = '{5'd1, 5'd4, 5'd8, 5'd14};
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_FIFO_CTL, {i[1:0], i[1:0], 4'h9});
         set_counts(tl[i], rl[i]);
         check("tx at level", dma_tx_req, 1'b1);
         check("rx at level", dma_rx_req, 1'b1);
         set_counts(tl[i] + 5'd1, rl[i] - 5'd1);
         check("tx past level", dma_tx_req, 1'b0);
         check("rx under level", dma_rx_req, 1'b0);
      end
      wr(`OFS_FIFO_CTL, 8'h00);
   endtask
   task automatic t_ack();
      set_counts(5'h00, 5'h00);
      @(posedge mclk) tx_go <= 1'b1;
      wait_lvl(0, 1'b0);
      @(posedge mclk) tx_go <= 1'b0;
      cyc(3);
      check("tx blocked", dma_tx_req, 1'b0);
      check("bus idle", idle_gate_hint_bus_clk, 1'b1);
      check("serial idle", idle_gate_hint_serial_clk, 1'b1);
      @(posedge mclk) tx_shift_busy <= 1'b1;
      cyc(2);
      check("bus busy", idle_gate_hint_bus_clk, 1'b0);
      check("serial busy", idle_gate_hint_serial_clk, 1'b0);
      @(posedge mclk) tx_shift_busy <= 1'b0;
      set_counts(5'h05, 5'h03);
      set_counts(5'h00, 5'h03);
      check("tx rearmed", dma_tx_req, 1'b1);
      @(posedge mclk) rx_go <= 1'b1;
      wait_lvl(1, 1'b0);
      @(posedge mclk) rx_go <= 1'b0;
      cyc(3);
      check("rx blocked", dma_rx_req, 1'b0);
      set_counts(5'h10, 5'h00);
   endtask
   task automatic t_legacy();
      wr(`OFS_CTRL, 8'h00);
      set_counts(5'h00, 5'h02);
      check("legacy tx", txrdy_n, 1'b0);
      check("legacy rx", rxrdy_n, 1'b0);
      check("no tx single", dma_tx_single, 1'b0);
      check("no rx single", dma_rx_single, 1'b0);
      // Partner still pulses its ack; without extended handshake it must not block
      @(posedge mclk) tx_go <= 1'b1;
      cyc(6);
      check("ack ignored", dma_tx_req, 1'b1);
      @(posedge mclk) tx_go <= 1'b0;
      set_counts(5'h10, 5'h00);
      check("legacy tx off", txrdy_n, 1'b1);
      check("legacy rx off", rxrdy_n, 1'b1);
      wr(`OFS_CTRL, 8'h02);
   endtask
   task automatic t_debug(input logic [7:0] c, input logic [5:0] irq, input logic tp);
      wr(`OFS_CTRL, c);
      wr(`OFS_FIFO_CTL, 8'ha9);
      @(posedge mclk);
      irq_src <= irq;
      tx_pop <= tp;
      rx_push <= ~tp;
      cyc(2);
      check("debug bus", debug, {18'h0, ~tp, tp, 4'ha, 1'b1, irq[5:1], irq[0] & ~c[4],
         1'b1});
      wr(`OFS_FIFO_CTL, 8'h00);
   endtask
   task automatic t_gates();
      set_counts(5'h00, 5'h00);
      check("rcv auto on", rcv_line_gate, 1'b1);
      check("xmit auto off", xmit_line_gate, 1'b0);
      check("permit rs232", xmit_permit, 1'b1);
      set_counts(5'h03, 5'h00);
      check("xmit auto on", xmit_line_gate, 1'b1);
      check("rcv auto off", rcv_line_gate, 1'b0);
      wr(`OFS_GATE_CTL, 8'h04);
      cyc(2);
      check("rcv manual", rcv_line_gate, 1'b1);
      check("xmit manual", xmit_line_gate, 1'b0);
      wr(`OFS_XCVR_CTL, 8'h01);
      cyc(2);
      check("rcv low true", rcv_line_gate, 1'b0);
      check("xmit low true", xmit_line_gate, 1'b1);
      check("mode rs485", multidrop_mode_flag, 1'b1);
      check("permit held", xmit_permit, 1'b0);
      wr(`OFS_GATE_CTL, 8'h0c);
      cyc(2);
      check("permit on", xmit_permit, 1'b1);
      check("xmit low on", xmit_line_gate, 1'b0);
      wr(`OFS_XCVR_CTL, 8'h06);
      wr(`OFS_GATE_CTL, 8'h03);
      set_counts(5'h10, 5'h00);
   endtask
   task automatic t_serial();
      wr(`OFS_DIV, 8'h03);
      wr(`OFS_CTRL, 8'h0a);
      @(posedge mclk) sout_core <= 1'b0;
      wait_lvl(2, 1'b0);
      @(posedge mclk) sout_core <= 1'b1;
      cyc(2);
      check("sout held", sout, 1'b0);
      wait_lvl(2, 1'b1);
      wr(`OFS_CTRL, 8'h02);
   endtask

   initial begin
      cyc(4);
      check("reset gate", rcv_line_gate, 1'b1);
      check("reset mode", multidrop_mode_flag, 1'b0);
      check("reset sout", sout, 1'b1);
      @(posedge mclk) rst_n <= 1'b1;
      t_regs();
      t_polarity();
      t_levels();
      t_ack();
      t_legacy();
      t_debug(8'h02, 6'h3f, 1'b1);
      t_debug(8'h02, 6'h2a, 1'b0);
      t_debug(8'h12, 6'h3f, 1'b0);
      t_gates();
      t_serial();
      end_of_test();
   end
endmodule
